/* verilog/xmb_bus.v */
/*
 * External memory bus for the core: multiplexed address/data on port 0,
 * high address or page on port 2, program/read/write strobes and the
 * address latch pulse. Also holds the external data page register.
 * Assumes the core holds a request until done, that port latch values come
 * from the core's own port registers, and that the configuration byte is
 * stable (it changes only in flash programming mode).
 */
`timescale 1ns/1ps
`include "xmb_defs.vh"
module xmb_bus #(
	parameter INT_PROG_BYTES = 17'h08000
) (
	input wire i_clk,
	input wire i_resetn,
	input wire i_ce,
	input wire [7:0] i_port_function_config,
	input wire i_external_fetch_select_n,

	input wire i_req,
	input wire [1:0] i_req_kind,
	input wire i_req_internal,
	input wire i_req_short_addr,
	input wire [15:0] i_req_addr,
	input wire [7:0] i_req_wdata,
	output wire o_req_ready,
	output reg o_done,
	output reg [7:0] o_rdata,

	input wire [15:0] i_pc,
	output wire o_fetch_external,

	input wire i_sfr_wr,
	input wire [7:0] i_sfr_addr,
	input wire [7:0] i_sfr_wdata,
	output wire [7:0] o_sfr_rdata,

	input wire [7:0] i_p0_latch,
	input wire [7:0] i_p2_latch,
	input wire [7:0] i_p0_pin,
	output reg [7:0] o_p0,
	output reg [7:0] o_p0_oe,
	output reg [7:0] o_p2,
	output reg o_p2_oe,
	output wire o_p0_open_drain,
	output reg o_address_latch,
	output reg o_program_read_strobe_n,
	output reg o_data_read_strobe_n,
	output reg o_data_store_strobe_n,
	output wire o_strobe_pins_owned,
	output wire o_port2_io_lost
);
	localparam ST_IDLE = 2'h0;
	localparam ST_ADDR = 2'h1;
	localparam ST_DATA = 2'h2;
	localparam ST_END = 2'h3;

	reg [1:0] state;
	reg [1:0] cnt;
	reg [1:0] kind;
	reg internal;
	reg short_addr;
	reg [15:0] addr;
	reg [7:0] wdata;
	reg [1:0] next_state;
	reg [1:0] next_cnt;

	reg [7:0] external_data_page;
	reg fetch_all_external;
	reg strap_taken;
	reg [1:0] strap_wait;

	reg [7:0] p0_s1;
	reg [7:0] p0_s2;
	reg fsel_s1;
	reg fsel_s2;

	reg [7:0] next_p0;
	reg [7:0] next_p0_oe;
	reg [7:0] next_p2;
	reg next_p2_oe;
	reg next_address_latch;
	reg next_program_read_strobe_n;
	reg next_data_read_strobe_n;
	reg next_data_store_strobe_n;

	wire port0_io_select = i_port_function_config[`XMB_CFG_P0_BIT];
	wire port2_3_io_select = i_port_function_config[`XMB_CFG_P23_BIT];
	wire bus_en = ~port0_io_select & ~port2_3_io_select;
	wire strobes_owned = ~port0_io_select | ~port2_3_io_select;
	wire [16:0] pc_wide = {1'b0, i_pc};

	// a request is taken only from idle
	wire take_req = (state == ST_IDLE) & i_req;
	wire short_req = i_req_short_addr & (i_req_kind != `XMB_KIND_FETCH);
	wire last_addr = (state == ST_ADDR) && (cnt == `XMB_ADDR_CYCLES - 1);

	assign o_strobe_pins_owned = strobes_owned;
	assign o_port2_io_lost = ~port2_3_io_select;
	assign o_p0_open_drain = ~bus_en;
	assign o_fetch_external = fetch_all_external | (bus_en & (pc_wide >= INT_PROG_BYTES));
	// in I/O mode requests finish at once and never touch the ports
	assign o_req_ready = (state == ST_IDLE);
	assign o_sfr_rdata = (i_sfr_addr == `XMB_PAGE_ADDR) ? external_data_page : 8'h00;

	// pins and the fetch strap come from outside the clock domain
	always @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			p0_s1 <= 8'h00;
			p0_s2 <= 8'h00;
			fsel_s1 <= 1'b1;
			fsel_s2 <= 1'b1;
		end else if (i_ce) begin
			p0_s1 <= i_p0_pin;
			p0_s2 <= p0_s1;
			fsel_s1 <= i_external_fetch_select_n;
			fsel_s2 <= fsel_s1;
		end
	end

	// strap caught once, on the third enabled edge after release
	always @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			strap_wait <= 2'h0;
			strap_taken <= 1'b0;
			fetch_all_external <= 1'b0;
		end else if (i_ce && !strap_taken) begin
			// synchroniser holds its reset level until two edges have passed
			if (strap_wait == 2'h2) begin
				strap_taken <= 1'b1;
				fetch_all_external <= ~fsel_s2;
			end else begin
				strap_wait <= strap_wait + 2'h1;
			end
		end
	end

	always @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			external_data_page <= `XMB_PAGE_RESET;
		end else if (i_ce && i_sfr_wr && i_sfr_addr == `XMB_PAGE_ADDR) begin
			external_data_page <= i_sfr_wdata;
		end
	end

	// next phase of the bus cycle
	always @* begin
		next_state = state;
		next_cnt = cnt;
		case (state)
		ST_IDLE: begin
			if (take_req && bus_en) begin
				next_cnt = 2'h0;
				next_state = ST_ADDR;
			end
		end
		ST_ADDR: begin
			if (last_addr) begin
				next_cnt = 2'h0;
				next_state = ST_DATA;
			end else begin
				next_cnt = cnt + 2'h1;
			end
		end
		ST_DATA: begin
			if (cnt == `XMB_STROBE_CYCLES - 1) begin
				next_cnt = 2'h0;
				next_state = ST_END;
			end else begin
				next_cnt = cnt + 2'h1;
			end
		end
		default: begin
			next_state = ST_IDLE;
		end
		endcase
	end

	always @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			state <= ST_IDLE;
			cnt <= 2'h0;
			kind <= `XMB_KIND_FETCH;
			internal <= 1'b0;
			short_addr <= 1'b0;
			addr <= 16'h0000;
			wdata <= 8'h00;
			o_done <= 1'b0;
			o_rdata <= 8'h00;
		end else if (i_ce) begin
			state <= next_state;
			cnt <= next_cnt;
			o_done <= 1'b0;
			if (take_req) begin
				if (!bus_en) begin
					// in I/O mode requests finish at once and never touch the ports
					o_done <= 1'b1;
				end else begin
					kind <= i_req_kind;
					internal <= i_req_internal;
					// fetches always carry a full address
					short_addr <= short_req;
					addr <= i_req_addr;
					wdata <= i_req_wdata;
				end
			end
			if (state == ST_END) begin
				o_done <= 1'b1;
				// synchroniser lags two edges: value seen while strobe still low
				if (kind != `XMB_KIND_WRITE) begin
					o_rdata <= internal ? 8'h00 : p0_s2;
				end
			end
		end
	end

	// port 2: page for short data moves, else high address byte
	always @* begin
		next_p2 = i_p2_latch;
		next_p2_oe = 1'b1;
		if (bus_en) begin
			if (take_req) begin
				if (short_req) begin
					next_p2 = external_data_page;
				end else begin
					next_p2 = i_req_addr[15:8];
				end
			end else begin
				next_p2 = short_addr ? external_data_page : addr[15:8];
			end
		end
	end

	// address latch pulse: one cycle, on the taking edge only
	always @* begin
		next_address_latch = bus_en & take_req;
	end

	// strobes stay high in I/O mode and outside the data phase
	always @* begin
		next_program_read_strobe_n = 1'b1;
		next_data_read_strobe_n = 1'b1;
		next_data_store_strobe_n = 1'b1;
		if (bus_en && state == ST_DATA) begin
			if (kind == `XMB_KIND_WRITE) begin
				// store strobe ends a cycle early so the data outlasts it
				next_data_store_strobe_n = (cnt == `XMB_STROBE_CYCLES - 1);
			end else if (kind == `XMB_KIND_FETCH) begin
				next_program_read_strobe_n = 1'b0;
			end else begin
				next_data_read_strobe_n = 1'b0;
			end
		end
	end

	// port 0: address, then data or zero, or released for a read
	always @* begin
		// I/O mode behaves as open drain: only a zero is driven
		next_p0 = i_p0_latch;
		next_p0_oe = ~i_p0_latch;
		if (bus_en) begin
			next_p0 = 8'hFF;
			next_p0_oe = 8'hFF;
			if (take_req) begin
				next_p0 = i_req_addr[7:0];
			end else if (state == ST_ADDR && !last_addr) begin
				next_p0 = addr[7:0];
			end else if (kind == `XMB_KIND_WRITE && state != ST_IDLE) begin
				// data goes out a cycle ahead of the strobe and stays after it
				next_p0 = internal ? 8'h00 : wdata;
			end else if (last_addr || state == ST_DATA) begin
				// reads release the pins, internal cycles show zero
				next_p0 = 8'h00;
				next_p0_oe = internal ? 8'hFF : 8'h00;
			end
		end
	end

	// pins registered so decode never glitches onto them
	always @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			o_p0 <= 8'hFF;
			o_p0_oe <= 8'h00;
			o_p2 <= 8'hFF;
			o_p2_oe <= 1'b0;
			o_address_latch <= 1'b0;
			o_program_read_strobe_n <= 1'b1;
			o_data_read_strobe_n <= 1'b1;
			o_data_store_strobe_n <= 1'b1;
		end else if (i_ce) begin
			o_p0 <= next_p0;
			o_p0_oe <= next_p0_oe;
			o_p2 <= next_p2;
			o_p2_oe <= next_p2_oe;
			o_address_latch <= next_address_latch;
			o_program_read_strobe_n <= next_program_read_strobe_n;
			o_data_read_strobe_n <= next_data_read_strobe_n;
			o_data_store_strobe_n <= next_data_store_strobe_n;
		end
	end
endmodule

/* verilog/xmb_defs.vh */
/*
 * Constants for the external memory bus block: configuration bit positions,
 * the external data page register address and its reset value, bus cycle
 * phase lengths.
 * Assumes inclusion by bare name from the bus block only.
 */
// What this block does
// - bus enabled only when both port select configuration bits are zero
// - with bus enabled every access address appears on ports 0 and 2
// - port 0 drives zero during data phase of internal accesses
// - program strobe for fetches; read and write strobes for data moves
// - fetch uses 16-bit address; data uses 16-bit or 8-bit address
// - page register holds port 2 through whole 8-bit data cycle
// - port 2 lost as I/O in bus mode; strobes forced onto P3.6, P3.7
// - low address and data share port 0; push-pull drivers in bus mode
// - low address valid on port 0 when latch pulse falls
// - write data precedes write strobe and outlasts it
// - read data sampled while read strobe low, two edges before it rises
// - port function from nonvolatile config; default is general I/O
// - access in I/O mode leaves port 0 and port 2 values unchanged
// - fetch select low at reset makes all fetches external
// - in bus mode fetch externally when PC is beyond internal memory
// - fetch drives PC high byte on port 2; bus pins dedicated outputs
// - config bit 1 set keeps port 0 as I/O; cleared gives bus only with bit 0 also cleared
// - config bit 0 set keeps port 2 as I/O; cleared loses port 2 and P3.6, P3.7, bus only with bit 1 also cleared
`ifndef XMB_DEFS_VH
`define XMB_DEFS_VH
`define XMB_CFG_P23_BIT 0
`define XMB_CFG_P0_BIT 1
`define XMB_CFG_RESET 8'hFF
`define XMB_PAGE_ADDR 8'h92
`define XMB_PAGE_RESET 8'h00
`define XMB_KIND_FETCH 2'h0
`define XMB_KIND_READ 2'h1
`define XMB_KIND_WRITE 2'h2
`define XMB_ADDR_CYCLES 2
`define XMB_STROBE_CYCLES 3
`endif

/* verif/xmb_mem_model.sv */
/* External address latch and byte memory; assumes push-pull bus pins. */
`timescale 1ns/1ps
module xmb_mem_model (
	input wire i_clk,
	input wire [7:0] i_p0,
	input wire i_ale,
	input wire i_rd_n,
	input wire i_program_read_strobe_n,
	input wire i_wr_n,
	output wire [7:0] o_p0
);
reg [7:0] mem [0:255];
reg [7:0] lat;
reg [7:0] alt = 8'h55;
// shared program and data memory
wire rd_n = i_rd_n & i_program_read_strobe_n;
always @(negedge i_ale) lat <= i_p0;
always @(posedge i_wr_n) mem[lat] <= i_p0;
// released bus toggles so a stale byte is never mistaken for data
always @(posedge i_clk) alt <= ~alt;
assign o_p0 = rd_n ? alt : mem[lat];
endmodule

/* verif/xmb_bus_chk.sv */
/* Pin checks for xmb_bus; assumes the config byte changes only in reset. */
`timescale 1ns/1ps
module xmb_bus_chk (
	input wire i_clk,
	input wire i_resetn,
	input wire [7:0] i_port_function_config,
	input wire i_req_internal,
	input wire i_req_short_addr,
	input wire [15:0] i_req_addr,
	input wire [7:0] i_req_wdata,
	input wire [7:0] o_p0,
	input wire [7:0] o_p2,
	input wire o_address_latch,
	input wire o_data_store_strobe_n
);
default clocking @(posedge i_clk); endclocking
default disable iff (!i_resetn);
wire io = i_port_function_config[1:0] != 2'h0;
cfg_gate_a: assert property (io |-> !o_address_latch) else $error("latch in io");
io_hold_a: assert property (io |=> $stable(o_p0) && $stable(o_p2))
	else $error("port moved");
one_ale_a: assert property ($rose(o_address_latch) |=> !o_address_latch[*6])
	else $error("extra latch");
ale_addr_a: assert property ($fell(o_address_latch) |-> o_p0 == i_req_addr[7:0])
	else $error("low addr");
hi_addr_a: assert property ($rose(o_address_latch) && !i_req_short_addr
	|-> o_p2 == i_req_addr[15:8]) else $error("high addr");
page_hold_a: assert property ($rose(o_address_latch) && i_req_short_addr
	|=> $stable(o_p2)[*5]) else $error("page moved");
wr_data_a: assert property ($fell(o_data_store_strobe_n) && !i_req_internal
	|-> $past(o_p0) == i_req_wdata ##2 o_p0 == i_req_wdata) else $error("write data");
zero_int_a: assert property (!o_data_store_strobe_n && i_req_internal
	|-> o_p0 == 8'h00) else $error("internal data");
endmodule

/* verif/xmb_bus_tb_top.sv */
/* Bench for xmb_bus; assumes the request walk of the design note. */
`timescale 1ns/1ps
module xmb_bus_tb_top;
logic clk = 0, rstn = 0, sel_n = 1, req = 0, intl = 0, shrt = 0, swr = 0;
logic [7:0] cfg = 8'hFF, wd = 0, sa = 8'h92, sd = 0, p2s = 0;
logic [1:0] kind = 0;
logic [15:0] addr = 0, pc = 0;
wire [7:0] p0, oe, p2, rdata, srd, m0;
wire [7:0] pin = (p0 & oe) | (m0 & ~oe);
wire ale, rd_n, ps_n, wr_n, done, fx, od, own, lost;
int num_errors = 0, checks = 0;
always #25 clk = ~clk;
xmb_bus xmb_bus_i (.i_clk(clk), .i_resetn(rstn), .i_ce(1'b1), .i_port_function_config(cfg),
	.i_external_fetch_select_n(sel_n), .i_req(req), .i_req_kind(kind), .i_req_internal(intl),
	.i_req_short_addr(shrt), .i_req_addr(addr), .i_req_wdata(wd), .o_req_ready(), .o_done(done),
	.o_rdata(rdata), .i_pc(pc), .o_fetch_external(fx), .i_sfr_wr(swr), .i_sfr_addr(sa),
	.i_sfr_wdata(sd), .o_sfr_rdata(srd), .i_p0_latch(8'hFF), .i_p2_latch(8'hFF), .i_p0_pin(pin),
	.o_p0(p0), .o_p0_oe(oe), .o_p2(p2), .o_p2_oe(), .o_p0_open_drain(od), .o_address_latch(ale),
	.o_program_read_strobe_n(ps_n), .o_data_read_strobe_n(rd_n), .o_data_store_strobe_n(wr_n),
	.o_strobe_pins_owned(own), .o_port2_io_lost(lost));
xmb_mem_model xmb_mem_model_i (.i_clk(clk), .i_p0(pin), .i_ale(ale), .i_rd_n(rd_n),
	.i_program_read_strobe_n(ps_n), .i_wr_n(wr_n), .o_p0(m0));
task chk(input string n, input logic [15:0] e, input logic [15:0] g);
	checks++;
	if (g !== e) begin
		num_errors++;
		$display("CHECK FAILED %s expected %h seen %h", n, e, g);
	end
endtask
task summarize;
	$display("checks %0d mismatches %0d", checks, num_errors);
	if (num_errors == 0 && checks > 0)
		$display("ALL CHECKS OK");
	else
		$display("CHECKS NOT OK");
	$finish;
endtask
task rst(input logic [7:0] c, input logic s);
	rstn = 0;
	cfg = c;
	sel_n = s;
	repeat (16) @(negedge clk);
	rstn = 1;
endtask
task acc(input logic [1:0] k, input logic i, s, input logic [15:0] a, input logic [7:0] d);
	@(negedge clk);
	kind = k;
	intl = i;
	shrt = s;
	addr = a;
	wd = d;
	req = 1;
	for (int n = 0; n < 12; n++) begin
		@(negedge clk);
		if (ale === 1'b1) p2s = p2;
		if (done === 1'b1) break;
	end
	chk("done", 1, done);
	req = 0;
endtask
initial begin
	for (int i = 3; i >= 0; i--) begin
		rst(8'hFC | i[7:0], 1);
		chk("lost", !i[0], lost);
		chk("own", i != 3, own);
		chk("od", i != 0, od);
		acc(2, 0, 0, 16'h8123, 8'h5A);
		if (i != 0) chk("p0 io", 8'hFF, p0);
		$display("config test %0d done", i);
	end
	acc(1, 0, 0, 16'h4523, 0);
	chk("read", 8'h5A, rdata);
	chk("page rst", 0, srd);
	sd = 8'h3C;
	swr = 1;
	@(negedge clk);
	swr = 0;
	chk("page", 8'h3C, srd);
	sa = 8'h93;
	@(negedge clk);
	chk("unmapped", 0, srd);
	acc(2, 0, 1, 16'h0044, 8'hA5);
	chk("p2 page", 8'h3C, p2s);
	acc(1, 0, 1, 16'h0044, 0);
	chk("short read", 8'hA5, rdata);
	acc(0, 0, 0, 16'h9023, 0);
	chk("fetch", 8'h5A, rdata);
	chk("p2 pc", 8'h90, p2s);
	acc(1, 1, 0, 16'h0123, 0);
	chk("int read", 0, rdata);
	acc(2, 1, 0, 16'h0123, 8'hEE);
	$display("bus test done");
	pc = 16'h7FFF;
	@(negedge clk);
	chk("fx in", 0, fx);
	pc = 16'h8000;
	@(negedge clk);
	chk("fx out", 1, fx);
	rst(8'hFC, 0);
	pc = 16'h0000;
	repeat (4) @(negedge clk);
	chk("fx strap", 1, fx);
	$display("fetch test done");
	summarize;
end
// about twenty times the expected run
initial begin
	repeat (3000) @(posedge clk);
	num_errors++;
	summarize;
end
endmodule
bind xmb_bus xmb_bus_chk xmb_bus_chk_i (.i_clk, .i_resetn, .i_port_function_config,
	.i_req_internal, .i_req_short_addr, .i_req_addr, .i_req_wdata, .o_p0, .o_p2,
	.o_address_latch, .o_data_store_strobe_n);
